// >>> rtl/output_pin_remap_8_to_19.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module output_pin_remap_8_to_19
  import pin_remap_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Peripheral output functions
  input wire logic [FUNC_COUNT-1:1] FUNC_OUT_I,
  input wire logic [FUNC_COUNT-1:1] FUNC_OE_I,
  // Remappable pins 8 to 19, bit 0 is pin 8
  output logic [PIN_COUNT-1:0] PIN_OUT_O,
  output logic [PIN_COUNT-1:0] PIN_OE_O,
  output logic [PIN_COUNT-1:0] PIN_MAPPED_O
);

  // Pack two selectors into one word, gaps held at zero
  function automatic logic [31:0] pack_pair(input sel_pair_type p);
    logic [31:0] w;
    w = WORD_ZERO;
    w[ODD_LSB +: SEL_W] = p.odd;
    w[EVEN_LSB +: SEL_W] = p.even;
    return w;
  endfunction

  // Map a byte address onto a mapping register index
  function automatic logic [3:0] pair_decode(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    case (a)
      OFF_PIN_OUTPUT_SELECT_8_9: r = 4'h8;
      OFF_PIN_OUTPUT_SELECT_10_11: r = 4'h9;
      OFF_PIN_OUTPUT_SELECT_12_13: r = 4'ha;
      OFF_PIN_OUTPUT_SELECT_14_15: r = 4'hb;
      OFF_PIN_OUTPUT_SELECT_16_17: r = 4'hc;
      OFF_PIN_OUTPUT_SELECT_18_19: r = 4'hd;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Bus request in one carrier
  apb_req_type req;
  assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I, addr: PADDR_I,
                 wdata: PWDATA_I, strb: PSTRB_I};

  // Bus state
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Error capture state
  logic err_flag_q;
  logic err_flag_d;
  logic [ADDR_W-1:0] err_addr_q;
  logic [ADDR_W-1:0] err_addr_d;

  // Phase and decode wires
  logic setup;
  logic access;
  logic [3:0] pair_code;
  logic pair_hit;
  logic [2:0] pair_idx;
  logic hit_mapped;
  logic hit_level;
  logic hit_error;
  logic hit_any;
  logic read_only_hit;
  logic refused;
  logic wr_pair;
  logic wr_error;
  logic err_clear;
  logic err_set;

  // Selector and pin state
  sel_pair_type pairs [PAIR_COUNT];
  logic [SEL_W-1:0] pin_sel [PIN_COUNT];
  pin_drive_type drives [PIN_COUNT];
  logic [PIN_COUNT-1:0] pin_data;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [PIN_COUNT-1:0] pin_mapped;

  // Read data sources
  logic [31:0] pair_word;
  logic [31:0] mapped_word;
  logic [31:0] level_word;
  logic [31:0] error_word;
  logic [31:0] read_word;

  // Phases: answer is always ready in the access cycle
  assign setup = req.sel & ~req.enable;
  assign access = req.sel & req.enable & pready_q;

  // Address decode
  assign pair_code = pair_decode(req.addr);
  assign pair_hit = pair_code[3];
  assign pair_idx = pair_code[2:0];
  assign hit_mapped = req.addr == OFF_MAPPED_STATUS;
  assign hit_level = req.addr == OFF_PIN_LEVEL_STATUS;
  assign hit_error = req.addr == OFF_BUS_ERROR;
  assign hit_any = pair_hit | hit_mapped | hit_level | hit_error;

  // Status words are read only; a write there is refused, not dropped silently
  assign read_only_hit = hit_mapped | hit_level;
  assign refused = ~hit_any | (req.write & read_only_hit);

  // Write strobes take effect only at the access edge
  assign wr_pair = access & req.write & pair_hit;
  assign wr_error = access & req.write & hit_error & req.strb[0];

  // Selector registers, pairs ascend from pins 8 and 9
  genvar g;
  generate
    for (g = 0; g < PAIR_COUNT; g++) begin : gen_pair
      // pin 15 removed on the small package
      selector_pair_reg #(
        .ODD_PRESENT(!(SMALL_PACKAGE && (g == ABSENT_PAIR)))
      ) u_pair (
        .clk_i(CLK_SYS_I),
        .resetn_i(RESETN_I),
        .wr_en_i(wr_pair && (pair_idx == 3'(g))),
        .strb_i(req.strb[1:0]),
        .wdata_i(req.wdata[REG_W-1:0]),
        .pair_o(pairs[g])
      );
      assign pin_sel[2 * g] = pairs[g].even;
      assign pin_sel[2 * g + 1] = pairs[g].odd;
    end
  endgenerate

  // One router per pin
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
      pin_output_router u_router (
        .clk_i(CLK_SYS_I),
        .resetn_i(RESETN_I),
        .sel_i(pin_sel[g]),
        .func_out_i(FUNC_OUT_I),
        .func_oe_i(FUNC_OE_I),
        .drive_o(drives[g])
      );
      assign pin_data[g] = drives[g].data;
      assign pin_oe[g] = drives[g].oe;
      assign pin_mapped[g] = drives[g].mapped;
    end
  endgenerate

  // Read words
  // bits 15-14 zero
  assign pair_word = pair_hit ? pack_pair(pairs[pair_idx]) : WORD_ZERO;
  assign mapped_word = {20'h00000, pin_mapped};
  assign level_word = {4'h0, pin_oe, 4'h0, pin_data};
  assign error_word = {16'h0000, err_addr_q, 7'h00, err_flag_q};

  // Read mux, zero for anything unmapped
  assign read_word = pair_hit ? pair_word :
                     hit_mapped ? mapped_word :
                     hit_level ? level_word :
                     hit_error ? error_word : WORD_ZERO;

  // Answer prepared in setup so every bus output leaves a flop
  assign pready_d = setup;
  assign pslverr_d = setup & refused;
  assign prdata_d = (setup & ~req.write & ~refused) ? read_word : WORD_ZERO;

  // Bus answer registers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WORD_ZERO;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Sticky refused-access flag; a new refusal beats a clear in the same edge
  assign err_set = access & pslverr_q;
  assign err_clear = wr_error & req.wdata[ERR_FLAG_BIT];
  assign err_flag_d = err_set | (err_flag_q & ~err_clear);
  assign err_addr_d = err_set ? req.addr : err_addr_q;

  // Error capture registers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      err_flag_q <= 1'b0;
      err_addr_q <= ERR_ADDR_RESET;
    end else begin
      err_flag_q <= err_flag_d;
      err_addr_q <= err_addr_d;
    end
  end

  // Outputs, all from flops
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;
  assign PIN_OUT_O = pin_data;
  assign PIN_OE_O = pin_oe;
  assign PIN_MAPPED_O = pin_mapped;

endmodule

// >>> rtl/pin_output_router.sv
`timescale 1ns/1ps
module pin_output_router
  import pin_remap_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Selector for this pin
  input wire logic [SEL_W-1:0] sel_i,
  // Peripheral outputs, function 0 means none
  input wire logic [FUNC_COUNT-1:1] func_out_i,
  input wire logic [FUNC_COUNT-1:1] func_oe_i,
  // Registered pin drive
  output pin_drive_type drive_o
);

  pin_drive_type drive_q;
  pin_drive_type drive_d;
  logic mapped;

  assign mapped = sel_i != FUNC_NONE;
  assign drive_d.mapped = mapped;
  assign drive_d.data = mapped ? func_out_i[sel_i] : 1'b0;
  assign drive_d.oe = mapped ? func_oe_i[sel_i] : 1'b0;

  // Registered so the pad sees no glitch while the selector changes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_q <= '{data: 1'b0, oe: 1'b0, mapped: 1'b0};
    end else begin
      drive_q <= drive_d;
    end
  end

  assign drive_o = drive_q;

endmodule

// >>> rtl/pin_remap_pkg.sv
package pin_remap_pkg;

  // Selector field layout
  localparam int SEL_W = 6;
  localparam int ODD_LSB = 8;
  localparam int EVEN_LSB = 0;
  localparam int REG_W = 16;

  // Pin and function counts
  localparam int PAIR_COUNT = 6;
  localparam int PIN_COUNT = 12;
  localparam int PIN_FIRST = 8;
  localparam int FUNC_COUNT = 64;
  localparam int ABSENT_PAIR = 3;

  // Values after reset
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [5:0] FUNC_NONE = 6'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] ERR_ADDR_RESET = 8'h00;

  // Byte offsets on the bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_8_9 = 8'h00;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_10_11 = 8'h04;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_12_13 = 8'h08;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_14_15 = 8'h0c;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_16_17 = 8'h10;
  localparam logic [7:0] OFF_PIN_OUTPUT_SELECT_18_19 = 8'h14;
  localparam logic [7:0] OFF_MAPPED_STATUS = 8'h18;
  localparam logic [7:0] OFF_PIN_LEVEL_STATUS = 8'h1c;
  localparam logic [7:0] OFF_BUS_ERROR = 8'h20;

  // Bus error register fields
  localparam int ERR_FLAG_BIT = 0;
  localparam int ERR_ADDR_LSB = 8;

  // One bus request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } apb_req_type;

  // Two selectors of one mapping register
  typedef struct packed {
    logic [SEL_W-1:0] odd;
    logic [SEL_W-1:0] even;
  } sel_pair_type;

  // Drive of one remappable pin
  typedef struct packed {
    logic data;
    logic oe;
    logic mapped;
  } pin_drive_type;

endpackage

// >>> rtl/selector_pair_reg.sv
`timescale 1ns/1ps
module selector_pair_reg
  import pin_remap_pkg::*;
#(
  parameter bit ODD_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [1:0] strb_i,
  input wire logic [REG_W-1:0] wdata_i,
  // Stored selectors
  output sel_pair_type pair_o
);

  sel_pair_type pair_q;
  sel_pair_type pair_d;
  logic wr_odd;
  logic wr_even;

  // Byte lane 1 holds the odd selector, lane 0 the even one
  // absent selector never loads
  assign wr_odd = wr_en_i & strb_i[1] & ODD_PRESENT;
  assign wr_even = wr_en_i & strb_i[0];
  assign pair_d.odd = wr_odd ? wdata_i[ODD_LSB +: SEL_W] : pair_q.odd;
  assign pair_d.even = wr_even ? wdata_i[EVEN_LSB +: SEL_W] : pair_q.even;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pair_q <= '{odd: SEL_RESET, even: SEL_RESET};
    end else begin
      pair_q <= pair_d;
    end
  end

  assign pair_o = ODD_PRESENT ? pair_q : sel_pair_type'{odd: SEL_RESET, even: pair_q.even};

endmodule

// >>> tb/output_pin_remap_8_to_19_bench.sv
`timescale 1ns/1ps
module output_pin_remap_8_to_19_bench;
  import pin_remap_pkg::*;
  // Small package, so the absent selector is exercised
  localparam bit SMALL = 1'b1;
  logic clk = 1'b0;
  logic rstn, psel, pen, pwr, pready, perr, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [FUNC_COUNT-1:1] fo, foe;
  logic [PIN_COUNT-1:0] pout, poe, pmap;
  logic [15:0] m [PAIR_COUNT];
  logic [35:0] x;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  always #10 clk = ~clk;

  output_pin_remap_8_to_19 #(.SMALL_PACKAGE(SMALL)) u_dut (
    .CLK_SYS_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .FUNC_OUT_I(fo), .FUNC_OE_I(foe), .PIN_OUT_O(pout), .PIN_OE_O(poe), .PIN_MAPPED_O(pmap)
  );

  task chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One transfer, request held until ready is seen
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // lanes update fields, absent field stays zero
  function logic [15:0] upd(int i, logic [15:0] o, logic [31:0] d, logic [3:0] s);
    upd = o;
    if (s[0]) upd[5:0] = d[5:0];
    if (s[1] && !(SMALL && i == ABSENT_PAIR)) upd[13:8] = d[13:8];
  endfunction

  // Expected {data, enable, mapped} of all pins
  function logic [35:0] pins();
    logic [5:0] s;
    pins = '0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      s = p[0] ? m[p / 2][13:8] : m[p / 2][5:0];
      if (s != 6'h00) begin
        pins[24 + p] = fo[s];
        pins[12 + p] = foe[s];
        pins[p] = 1'b1;
      end
    end
  endfunction

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {rstn, psel, pen, pwr, paddr, pwdata, pstrb, fo, foe} = '0;
    void'($urandom(61));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < PAIR_COUNT; i++) begin
      m[i] = '0;
      apb(1'b0, ADDR_W'(4 * i), '0, '0);
      chk(36'(r), '0);
    end
    // First all ones per register, then random data and lanes
    for (int k = 0; k < 40; k++) begin
      int i;
      logic [31:0] d;
      logic [3:0] s;
      i = (k < PAIR_COUNT) ? k : int'($urandom % PAIR_COUNT);
      d = (k < PAIR_COUNT) ? 32'hffff_ffff : $urandom;
      s = (k < PAIR_COUNT) ? 4'hf : 4'($urandom);
      apb(1'b1, ADDR_W'(4 * i), d, s);
      m[i] = upd(i, m[i], d, s);
      apb(1'b0, ADDR_W'(4 * i), '0, '0);
      chk(36'({e, r}), 36'(m[i]));
      fo <= 63'({$urandom, $urandom});
      foe <= 63'({$urandom, $urandom});
      repeat (3) @(posedge clk);
      chk({pout, poe, pmap}, pins());
    end
    // Mapped status mirrors selectors
    x = pins();
    apb(1'b0, OFF_MAPPED_STATUS, '0, '0);
    chk(36'(r), 36'(x[11:0]));
    apb(1'b0, OFF_PIN_LEVEL_STATUS, '0, '0);
    chk(36'(r), 36'({4'h0, x[23:12], 4'h0, x[35:24]}));
    // Refused writes leave selectors alone
    apb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
    chk(36'({e, r}), 36'h1_0000_0000);
    apb(1'b1, OFF_MAPPED_STATUS, 32'hffff_ffff, 4'hf);
    chk(36'(e), 36'h1);
    // Error register holds the refused address; clearing keeps the address
    apb(1'b0, OFF_BUS_ERROR, '0, '0);
    chk(36'(r), 36'({OFF_MAPPED_STATUS, 8'h01}));
    apb(1'b1, OFF_BUS_ERROR, 32'h0000_0001, 4'h1);
    apb(1'b0, OFF_BUS_ERROR, '0, '0);
    chk(36'(r), 36'({OFF_MAPPED_STATUS, 8'h00}));
    apb(1'b0, OFF_PIN_OUTPUT_SELECT_8_9, '0, '0);
    chk(36'(r), 36'(m[0]));
    // Reset in mid-run clears everything
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFF_PIN_OUTPUT_SELECT_18_19, '0, '0);
    chk(36'(r), '0);
    chk(36'(pmap), '0);
    apb(1'b0, OFF_BUS_ERROR, '0, '0);
    chk(36'(r), '0);
    conclude();
  end
endmodule

// >>> tb/output_pin_remap_8_to_19_monitor.sv
`timescale 1ns/1ps
module output_pin_remap_8_to_19_monitor
  import pin_remap_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // Bus side
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Pin side
  input wire logic [PIN_COUNT-1:0] PIN_OUT_O,
  input wire logic [PIN_COUNT-1:0] PIN_OE_O,
  input wire logic [PIN_COUNT-1:0] PIN_MAPPED_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // Selector registers are the aligned words below the status words
  wire sel_reg = PADDR_I < OFF_MAPPED_STATUS && PADDR_I[1:0] == 2'b00;
  wire ro_reg = PADDR_I == OFF_MAPPED_STATUS || PADDR_I == OFF_PIN_LEVEL_STATUS;

  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
  a_ready_one_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
  a_idle_bus_quiet: assert property (!PREADY_O |-> PRDATA_O == WORD_ZERO && !PSLVERR_O) else $error("bus not idle");
  a_unused_bits_zero: assert property (PREADY_O && sel_reg |-> PRDATA_O[31:14] == '0 && PRDATA_O[7:6] == '0)
    else $error("unused bits read nonzero");
  a_selector_accepted: assert property (PREADY_O && sel_reg |-> !PSLVERR_O)
    else $error("selector access refused");
  a_unmapped_refused: assert property (PREADY_O && PADDR_I > OFF_BUS_ERROR |-> PSLVERR_O && PRDATA_O == WORD_ZERO)
    else $error("unmapped access accepted");
  a_ro_write_refused: assert property (PREADY_O && PWRITE_I && ro_reg |-> PSLVERR_O) else $error("status write taken");
  a_unmapped_pin_quiet: assert property (((PIN_OE_O | PIN_OUT_O) & ~PIN_MAPPED_O) == '0)
    else $error("unmapped pin driven");
  a_reset_unmapped: assert property ($rose(RESETN_I) |-> PIN_MAPPED_O == '0 && PIN_OE_O == '0)
    else $error("pin mapped after reset");
  a_pin15_absent: assert property (SMALL_PACKAGE |-> !PIN_MAPPED_O[7]) else $error("absent pin mapped");
endmodule

bind output_pin_remap_8_to_19 output_pin_remap_8_to_19_monitor #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_monitor (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O), .PIN_MAPPED_O(PIN_MAPPED_O)
);
